// ==== hw/core_pkg.sv ====
// How it works
// - call pushes pc plus one onto the two-level stack first.
// - call loads the eight-bit literal into pc bits 7..0.
// - call forces pc bit 9 to zero.
// - call copies page bits 2..1 into pc bits 11..10.
// - call takes two instruction cycles.
// - clear-register writes zero into the addressed data register.
// - clear-register with destination 0 also zeroes the working register.
// - clear-register with destination 1 leaves the working register alone.
// - watchdog clear zeroes the watchdog counter and its prescaler.
// - watchdog clear sets timeout and powerdown flags to one.
// - decrement stores by destination bit, updates carry, digit carry, zero.
// - decrement-skip stores by destination bit, carry, digit carry, zero untouched.
// - decrement-skip skips next instruction on zero, else one cycle.
// - a skip runs a no-operation cycle, two cycles in all.
package core_pkg;
  localparam int DATA_W  = 8;
  localparam int PC_W    = 12;
  localparam int INSTR_W = 12;
  localparam int FADDR_W = 5;
  localparam int DEPTH   = 32;
  localparam int PAGE_W  = 3;
  localparam int DOG_W   = 8;
  localparam int PRESC_W = 8;
  localparam int ADDR_W  = 8;

  // register byte offsets
  localparam logic [7:0] OFS_INSTR  = 8'h00;
  localparam logic [7:0] OFS_W      = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_PC     = 8'h0c;
  localparam logic [7:0] OFS_PAGE   = 8'h10;
  localparam logic [7:0] OFS_STACK0 = 8'h14;
  localparam logic [7:0] OFS_STACK1 = 8'h18;
  localparam logic [7:0] OFS_DOG    = 8'h1c;
  localparam logic [7:0] OFS_FADDR  = 8'h20;
  localparam logic [7:0] OFS_FDATA  = 8'h24;

  // status bit positions
  localparam int ST_C     = 0;
  localparam int ST_DIGIT = 1;
  localparam int ST_Z     = 2;
  localparam int ST_POWER = 3;
  localparam int ST_TIME  = 4;
  localparam int ST_BADOP = 5;

  // values after reset
  localparam logic [7:0]  RST_STATUS = 8'h18;
  localparam logic [7:0]  RST_W      = 8'h00;
  localparam logic [11:0] RST_PC     = 12'h000;
  localparam logic [2:0]  RST_PAGE   = 3'h0;
  localparam logic [7:0]  DOG_CLEAR  = 8'h00;
  localparam logic [7:0]  PRESC_CLR  = 8'h00;

  // opcode fields
  localparam logic [3:0]  OP_CALL   = 4'h9;
  localparam logic [5:0]  OP_CLR_REG  = 6'h01;
  localparam logic [5:0]  OP_COMPL    = 6'h09;
  localparam logic [5:0]  OP_DEC      = 6'h03;
  localparam logic [5:0]  OP_DEC_SKIP = 6'h0b;
  localparam logic [11:0] OP_CLR_ACC  = 12'h040;
  localparam logic [11:0] OP_DOG_CLR  = 12'h004;

  typedef enum logic [0:0] {alu_dec, alu_com} alu_op_t;
  typedef enum logic [1:0] {st_idle, st_exec, st_second} state_t;
endpackage

// ==== hw/exec_alu.sv ====
`timescale 1ns/10ps
// decrement and complement datapath with flag results
module exec_alu (
  input  core_pkg::alu_op_t op,
  input  wire logic [7:0]   operand,
  output logic [7:0]        result,
  output logic              carry,
  output logic              dcarry,
  output logic              zero
);
  // carry means no borrow, as in a subtract
  always_comb begin
    result = operand - 8'h01;
    carry  = operand != 8'h00;
    dcarry = operand[3:0] != 4'h0;
    if (op == core_pkg::alu_com) begin
      result = ~operand;
    end
    zero = result == 8'h00;
  end
endmodule // exec_alu

// ==== hw/file_regs.sv ====
`timescale 1ns/10ps
// data register file, core port beats bus port on a clash
module file_regs (
  input  wire logic       clk,
  input  wire logic [4:0] core_addr,
  input  wire logic       core_we,
  input  wire logic [7:0] core_wdata,
  output logic [7:0]      core_rdata,
  input  wire logic [4:0] bus_addr,
  input  wire logic       bus_we,
  input  wire logic [7:0] bus_wdata,
  output logic [7:0]      bus_rdata
);
  logic [7:0] mem [core_pkg::DEPTH];

  // asynchronous reads keep execution single cycle
  assign core_rdata = mem[core_addr];
  assign bus_rdata  = mem[bus_addr];

  // no reset: data memory is undefined after power-up
  always_ff @(posedge clk) begin
    if (core_we) begin
      mem[core_addr] <= core_wdata;
    end
    if (bus_we && !(core_we && core_addr == bus_addr)) begin
      mem[bus_addr] <= bus_wdata;
    end
  end
endmodule // file_regs

// ==== hw/call_clear_decrement_exec.sv ====
// The Avalon-MM slave port and the placing of the registers were decided locally.
`timescale 1ns/10ps
module call_clear_decrement_exec (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             busy,
  output logic             watchdog_clear
);
  core_pkg::state_t state_q, state_d;
  logic [11:0] instr_q, instr_d;
  logic [7:0]  w_q, w_d;
  logic [7:0]  status_q, status_d;
  logic [11:0] pc_q, pc_d;
  logic [2:0]  page_q, page_d;
  logic [11:0] stk0_q, stk0_d;
  logic [11:0] stk1_q, stk1_d;
  // watchdog counter and its prescaler, both free running
  logic [7:0]  dog_q, dog_d;
  logic [7:0]  presc_q, presc_d;
  logic [4:0]  faddr_q, faddr_d;
  logic        rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic        wdclr_q, wdclr_d;

  logic [31:0] bmask;
  logic [31:0] wmerge_pc;
  logic [31:0] wmerge_lo;
  logic        acc_w;
  logic        instr_wr;
  logic        dest;
  logic [4:0]  fsel;
  logic        is_call;
  // one decode flag per supported instruction
  logic        is_clr_acc;
  logic        is_dog_clr;
  logic        is_clr_reg;
  logic        is_compl;
  logic        is_dec;
  logic        is_dec_skip;
  logic        is_known;
  logic [7:0]  f_val;
  logic [7:0]  alu_res;
  logic        alu_c;
  logic        alu_digit;
  logic        alu_z;
  logic        core_we;
  logic [7:0]  core_wdata;
  logic        bus_we;
  logic [7:0]  bus_rdata;
  core_pkg::alu_op_t alu_op;

  // byte enables expanded to a bit mask
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_mask
      assign bmask[gi*8 +: 8] = {8{avs_byteenable[gi]}};
    end
  endgenerate

  // merged write values keep lanes that are not enabled
  assign wmerge_pc = ({20'h00000, pc_q} & ~bmask) | (avs_writedata & bmask);
  assign wmerge_lo = ({24'h000000, w_q} & ~bmask) | (avs_writedata & bmask);

  // instruction writes stall while a previous one still runs
  assign instr_wr = avs_write && avs_address == core_pkg::OFS_INSTR;
  assign avs_waitrequest = (instr_wr && state_q != core_pkg::st_idle)
                         || (avs_read && !rvalid_q);
  assign acc_w = avs_write && !avs_waitrequest;
  assign avs_readdata = rdata_q;
  assign busy = state_q != core_pkg::st_idle;
  assign watchdog_clear = wdclr_q;

  // opcode decode of the held instruction
  assign dest      = instr_q[5];
  assign fsel      = instr_q[4:0];
  assign is_call   = instr_q[11:8] == core_pkg::OP_CALL;
  // the exact clear-accumulator word shares its top bits with
  // clear-register, so it is matched whole and wins over it
  assign is_clr_acc  = instr_q == core_pkg::OP_CLR_ACC;
  assign is_dog_clr  = instr_q == core_pkg::OP_DOG_CLR;
  assign is_clr_reg  = instr_q[11:6] == core_pkg::OP_CLR_REG && !is_clr_acc;
  assign is_compl    = instr_q[11:6] == core_pkg::OP_COMPL;
  assign is_dec      = instr_q[11:6] == core_pkg::OP_DEC;
  assign is_dec_skip = instr_q[11:6] == core_pkg::OP_DEC_SKIP;
  // anything else runs as a one-cycle no-op and flags it in status
  assign is_known    = is_call || is_clr_acc || is_dog_clr || is_clr_reg
                     || is_compl || is_dec || is_dec_skip;
  // one subtractor serves both decrement forms
  assign alu_op      = is_compl ? core_pkg::alu_com : core_pkg::alu_dec;

  exec_alu u_alu (
    .op      (alu_op),
    .operand (f_val),
    .result  (alu_res),
    .carry   (alu_c),
    .dcarry  (alu_digit),
    .zero    (alu_z)
  );

  // core write port: clear, or result stored back when dest is 1
  always_comb begin
    core_we    = 1'b0;
    core_wdata = alu_res;
    if (state_q == core_pkg::st_exec) begin
      if (is_clr_reg) begin
        core_we    = 1'b1;
        core_wdata = 8'h00;
      end else if ((is_compl || is_dec || is_dec_skip) && dest) begin
        core_we = 1'b1;
      end
    end
  end

  assign bus_we = acc_w && avs_address == core_pkg::OFS_FDATA
                && avs_byteenable[0];

  file_regs u_regs (
    .clk        (clk),
    .core_addr  (fsel),
    .core_we    (core_we),
    .core_wdata (core_wdata),
    .core_rdata (f_val),
    .bus_addr   (faddr_q),
    .bus_we     (bus_we),
    .bus_wdata  (avs_writedata[7:0]),
    .bus_rdata  (bus_rdata)
  );

  // read data are registered, so every read waits one cycle
  always_comb begin
    rvalid_d = avs_read && !rvalid_q;
    rdata_d  = rdata_q;
    if (avs_read && !rvalid_q) begin
      case (avs_address)
        core_pkg::OFS_INSTR:  rdata_d = {20'h00000, instr_q};
        core_pkg::OFS_W:      rdata_d = {24'h000000, w_q};
        core_pkg::OFS_STATUS: rdata_d = {23'h000000, busy, status_q};
        core_pkg::OFS_PC:     rdata_d = {20'h00000, pc_q};
        core_pkg::OFS_PAGE:   rdata_d = {29'h00000000, page_q};
        core_pkg::OFS_STACK0: rdata_d = {20'h00000, stk0_q};
        core_pkg::OFS_STACK1: rdata_d = {20'h00000, stk1_q};
        core_pkg::OFS_DOG:    rdata_d = {16'h0000, presc_q, dog_q};
        core_pkg::OFS_FADDR:  rdata_d = {27'h0000000, faddr_q};
        core_pkg::OFS_FDATA:  rdata_d = {24'h000000, bus_rdata};
        default:              rdata_d = 32'h00000000;
      endcase
    end
  end

  // software writes first, execution below overrides them
  always_comb begin
    state_d  = state_q;
    instr_d  = instr_q;
    w_d      = w_q;
    status_d = status_q;
    pc_d     = pc_q;
    page_d   = page_q;
    stk0_d   = stk0_q;
    stk1_d   = stk1_q;
    faddr_d  = faddr_q;
    wdclr_d  = 1'b0;
    // free-running watchdog: prescaler wrap advances the counter
    presc_d  = presc_q + 8'h01;
    dog_d    = (presc_q == 8'hff) ? dog_q + 8'h01 : dog_q;
    if (acc_w) begin
      case (avs_address)
        core_pkg::OFS_W:      w_d = wmerge_lo[7:0];
        core_pkg::OFS_STATUS: status_d = avs_byteenable[0]
                                ? avs_writedata[7:0] : status_q;
        core_pkg::OFS_PC:     pc_d = wmerge_pc[11:0];
        core_pkg::OFS_PAGE:   page_d = avs_byteenable[0]
                                ? avs_writedata[2:0] : page_q;
        core_pkg::OFS_FADDR:  faddr_d = avs_byteenable[0]
                                ? avs_writedata[4:0] : faddr_q;
        default: ;
      endcase
    end
    case (state_q)
      core_pkg::st_idle: begin
        if (acc_w && instr_wr) begin
          instr_d = avs_writedata[11:0];
          state_d = core_pkg::st_exec;
        end
      end
      core_pkg::st_exec: begin
        pc_d    = pc_q + 12'h001;
        state_d = core_pkg::st_idle;
        status_d[core_pkg::ST_BADOP] = !is_known;
        if (is_call) begin
          stk1_d  = stk0_q;
          stk0_d  = pc_q + 12'h001;
          state_d = core_pkg::st_second;
        end
        if (is_clr_acc) begin
          w_d = 8'h00;
        end
        if (is_clr_reg && !dest) begin
          w_d = 8'h00;
        end
        // with dest set the working register holds its value
        // clearing here beats the free-running increment above
        if (is_dog_clr) begin
          dog_d   = core_pkg::DOG_CLEAR;
          presc_d = core_pkg::PRESC_CLR;
          wdclr_d = 1'b1;
          status_d[core_pkg::ST_TIME]  = 1'b1;
          status_d[core_pkg::ST_POWER] = 1'b1;
        end
        if ((is_compl || is_dec || is_dec_skip) && !dest) begin
          w_d = alu_res;
        end
        if (is_compl) begin
          status_d[core_pkg::ST_Z] = alu_z;
        end
        if (is_dec) begin
          status_d[core_pkg::ST_C]     = alu_c;
          status_d[core_pkg::ST_DIGIT] = alu_digit;
          status_d[core_pkg::ST_Z]     = alu_z;
        end
        // decrement-skip leaves carry, digit carry and zero alone
        if (is_dec_skip && alu_z) begin
          state_d = core_pkg::st_second;
        end
      end
      core_pkg::st_second: begin
        state_d = core_pkg::st_idle;
        if (is_call) begin
          pc_d[7:0]  = instr_q[7:0];
          pc_d[8]    = 1'b0;
          pc_d[11:9] = page_q;
          pc_d[9]    = 1'b0;
        end else begin
          // discarded instruction: no-op cycle steps over it
          pc_d = pc_q + 12'h001;
        end
      end
      default: state_d = core_pkg::st_idle;
    endcase
  end

  // all control state registered here
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q  <= core_pkg::st_idle;
      instr_q  <= 12'h000;
      w_q      <= core_pkg::RST_W;
      status_q <= core_pkg::RST_STATUS;
      pc_q     <= core_pkg::RST_PC;
      page_q   <= core_pkg::RST_PAGE;
      stk0_q   <= 12'h000;
      stk1_q   <= 12'h000;
      dog_q    <= core_pkg::DOG_CLEAR;
      presc_q  <= core_pkg::PRESC_CLR;
      faddr_q  <= 5'h00;
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h00000000;
      wdclr_q  <= 1'b0;
    end else begin
      state_q  <= state_d;
      instr_q  <= instr_d;
      w_q      <= w_d;
      status_q <= status_d;
      pc_q     <= pc_d;
      page_q   <= page_d;
      stk0_q   <= stk0_d;
      stk1_q   <= stk1_d;
      dog_q    <= dog_d;
      presc_q  <= presc_d;
      faddr_q  <= faddr_d;
      rvalid_q <= rvalid_d;
      rdata_q  <= rdata_d;
      wdclr_q  <= wdclr_d;
    end
  end
endmodule // call_clear_decrement_exec

// ==== bench/call_clear_decrement_exec_checker.sv ====
`timescale 1ns/10ps
module call_clear_decrement_exec_checker (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        busy,
  input wire logic        watchdog_clear
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // instruction word accepted by the bus while idle
  logic       go;
  logic [11:0] iw;
  assign go = avs_write && !avs_waitrequest && avs_address == 8'h00;
  assign iw = avs_writedata[11:0];

  instr_start_a: assert property (go |=> busy)
    else $error("instruction did not start");
  call_two_a: assert property (go && iw[11:8] == core_pkg::OP_CALL
    |=> busy [*2] ##1 !busy) else $error("call length wrong");
  skip_bound_a: assert property ($rose(busy) |-> ##[1:2] !busy)
    else $error("busy too long");
  clear_acc_a: assert property (go && iw == core_pkg::OP_CLR_ACC
    |=> busy ##1 !busy) else $error("clear accumulator length");
  dog_pulse_a: assert property (go && iw == core_pkg::OP_DOG_CLR
    |=> ##1 watchdog_clear) else $error("no watchdog clear pulse");
  dog_cause_a: assert property (watchdog_clear |-> $past(busy))
    else $error("stray watchdog clear");
  instr_stall_a: assert property (
    busy && avs_write && avs_address == 8'h00 |-> avs_waitrequest)
    else $error("instruction taken while busy");
  read_wait_a: assert property (
    $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("read wait wrong");

  // main scenarios reached
  cover property (go && iw[11:8] == core_pkg::OP_CALL);
  cover property (watchdog_clear);
  cover property (busy && avs_write && avs_waitrequest);
endmodule // call_clear_decrement_exec_checker

bind call_clear_decrement_exec call_clear_decrement_exec_checker u_chk (
  .clk(clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .busy(busy),
  .watchdog_clear(watchdog_clear));

// ==== bench/call_clear_decrement_exec_tb_top.sv ====
`timescale 1ns/10ps
module call_clear_decrement_exec_tb_top;
  logic        clk = 1'h0;
  logic        srst = 1'h1;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'h0;
  logic        avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        busy;
  logic        watchdog_clear;
  int          n_fail = 0;
  int          tests_run = 0;
  logic [31:0] rd, st, pc, w, v;
  logic [11:0] ins, a0;
  logic [7:0]  k1, k2;
  logic [2:0]  p;
  logic [5:0]  ops [4] = '{core_pkg::OP_CLR_REG, core_pkg::OP_DEC,
                           core_pkg::OP_COMPL, core_pkg::OP_DEC_SKIP};
  // corners: skip on zero, borrow, digit borrow, complement to zero
  logic [11:0] ci [5] = '{12'h2e3, 12'h0ca, 12'h0f1, 12'h25c, 12'h040};
  logic [7:0]  cv [5] = '{8'h01, 8'h00, 8'h10, 8'hff, 8'h5a};

  always #10 clk = ~clk;

  call_clear_decrement_exec u_call_clear_decrement_exec (
    .clk(clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .busy(busy),
    .watchdog_clear(watchdog_clear));

  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // hold the request until waitrequest is seen low at an edge
  task automatic bus_wait;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'h0 && n < 64);
    if (n >= 64) n_fail++;
  endtask

  // one idle cycle after each transfer keeps drivers single per step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'h1;
    bus_wait();
    avs_write <= 1'h0;
    @(posedge clk);
  endtask

  task automatic rdr(input logic [7:0] a, output logic [31:0] d);
    avs_address <= a;
    avs_read <= 1'h1;
    bus_wait();
    d = avs_readdata;
    avs_read <= 1'h0;
    @(posedge clk);
  endtask

  task automatic exec(input logic [11:0] i);
    int n;
    n = 0;
    wr(8'h00, {20'h0, i});
    while (busy !== 1'h0 && n < 8) begin
      @(posedge clk);
      n++;
    end
  endtask

  // expected register, accumulator, status and pc after one op
  function automatic void model(input logic [11:0] i, inout logic [31:0] f,
    inout logic [31:0] a, inout logic [31:0] s, inout logic [31:0] q);
    logic [7:0] r;
    r = 8'h00;
    s[5] = 1'h0;
    q = {20'h0, q[11:0] + 12'h001};
    if (i == core_pkg::OP_CLR_ACC) a = 32'h0;
    else begin
      case (i[11:6])
        core_pkg::OP_COMPL: begin
          r = ~f[7:0];
          s[2] = (r == 8'h00);
        end
        core_pkg::OP_DEC: begin
          r = f[7:0] - 8'h01;
          s[0] = (f[7:0] != 8'h00);
          s[1] = (f[3:0] != 4'h0);
          s[2] = (r == 8'h00);
        end
        core_pkg::OP_DEC_SKIP: begin
          r = f[7:0] - 8'h01;
          if (r == 8'h00) q = {20'h0, q[11:0] + 12'h001};
        end
        default: r = 8'h00;
      endcase
      if (i[5] || i[11:6] == core_pkg::OP_CLR_REG) f = {24'h0, r};
      if (!i[5]) a = {24'h0, r};
    end
  endfunction

  // watchdog: cuts a hang short well past the expected run length
  initial begin
    #400000;
    n_fail++;
    close_out();
  end

  initial begin
    void'($urandom(32'hf11341ab));
    repeat (2) @(posedge clk);
    srst <= 1'h0;
    rdr(8'h08, rd);
    check(rd, 32'h18);
    rdr(8'h3c, rd);
    check(rd, 32'h0);
    $display("reset test done");
    for (int k = 0; k < 45; k++) begin
      ins = (k < 5) ? ci[k] : {ops[$urandom % 4], 6'($urandom)};
      v = {24'h0, (k < 5) ? cv[k] : 8'($urandom)};
      w = {24'h0, 8'($urandom)};
      wr(8'h20, {27'h0, ins[4:0]});
      wr(8'h24, v);
      wr(8'h04, w);
      rdr(8'h08, st);
      rdr(8'h0c, pc);
      model(ins, v, w, st, pc);
      exec(ins);
      rdr(8'h24, rd);
      check(rd, v);
      rdr(8'h04, rd);
      check(rd, w);
      rdr(8'h08, rd);
      check(rd, st);
      rdr(8'h0c, rd);
      check(rd, pc);
    end
    $display("register op test done");
    // second call is stalled behind the first one
    for (int j = 0; j < 2; j++) begin
      p = (j == 0) ? 3'h7 : 3'($urandom);
      a0 = 12'($urandom);
      k1 = 8'($urandom);
      k2 = 8'($urandom);
      wr(8'h10, {29'h0, p});
      wr(8'h0c, {20'h0, a0});
      wr(8'h00, {20'h0, 4'h9, k1});
      exec({4'h9, k2});
      rdr(8'h0c, rd);
      check(rd, {20'h0, p[2], p[1], 2'h0, k2});
      rdr(8'h14, rd);
      check(rd, {20'h0, p[2], p[1], 2'h0, k1} + 32'h1);
      rdr(8'h18, rd);
      check(rd, {20'h0, a0 + 12'h001});
    end
    $display("call test done");
    repeat (300) @(posedge clk);
    rdr(8'h1c, rd);
    check(32'(rd[7:0] != 8'h00), 32'h1);
    // flags cleared first so that the set can be seen
    wr(8'h08, 32'h0);
    exec(core_pkg::OP_DOG_CLR);
    rdr(8'h1c, rd);
    check(rd & 32'hf0ff, 32'h0);
    rdr(8'h08, rd);
    check(rd & 32'h18, 32'h18);
    $display("watchdog test done");
    close_out();
  end
endmodule // call_clear_decrement_exec_tb_top
